// [rtl/pts_pkg.sv]
// package of constants and carrier types for the packet timing and sync configuration bank
package pts_pkg;

	// =====================================================================
	// register map
	localparam logic [9:0] ADDR_PACKET_OPTIONS = 10'h108;
	localparam logic [9:0] ADDR_RX_CMD_DELAY = 10'h109;
	localparam logic [9:0] ADDR_TX_CMD_DELAY = 10'h10a;
	localparam logic [9:0] ADDR_CMD_DELAY_EXT = 10'h10b;
	localparam logic [9:0] ADDR_SYNC_LOW = 10'h10c;
	localparam logic [9:0] ADDR_SYNC_MID = 10'h10d;
	localparam logic [9:0] ADDR_SYNC_HIGH = 10'h10e;

	// =====================================================================
	// reset values
	localparam logic [7:0] RST_PACKET_OPTIONS = 8'h04;
	localparam logic [7:0] RST_RX_CMD_DELAY = 8'hc0;
	localparam logic [7:0] RST_TX_CMD_DELAY = 8'hc0;
	localparam logic [7:0] RST_CMD_DELAY_EXT = 8'h00;
	localparam logic [7:0] RST_SYNC_LOW = 8'h31;
	localparam logic [7:0] RST_SYNC_MID = 8'h7a;
	localparam logic [7:0] RST_SYNC_HIGH = 8'haa;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// =====================================================================
	// field positions in packet_options
	localparam int BIT_EXTENSION_EN = 4;
	localparam int BIT_SYNTH_SKIP = 3;
	localparam int BIT_FCS_OFF = 0;

	// =====================================================================
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int DELAY_STEP_NS = 1000;
	localparam int EXT_STEP_US = 4;
	// one microsecond step as whole clock cycles, at least one
	localparam int CYC_PER_US_RAW = DELAY_STEP_NS / CLK_PERIOD_NS;
	localparam int CYC_PER_US = (CYC_PER_US_RAW < 1) ? 1 : CYC_PER_US_RAW;
	localparam int DELAY_US_W = 11;
	localparam int PRESCALE_W = 16;

	// =====================================================================
	// sync word
	localparam int SYNC_W = 24;
	localparam logic [4:0] SYNC_LEN_MAX = 5'd24;

	// =====================================================================
	// types
	typedef struct packed {
		logic wr;
		logic rd;
		logic [9:0] addr;
		logic [7:0] data;
	} pts_reg_req_t;

	typedef struct packed {
		logic received;
		logic check_ok;
	} pts_frame_evt_t;

	typedef struct packed {
		logic rx_check;
		logic rx_overwrite_quality;
		logic tx_append;
		logic tx_from_buffer;
	} pts_fcs_ctl_t;

	typedef enum logic [1:0] {
		PTS_IDLE,
		PTS_RX_WAIT,
		PTS_TX_WAIT
	} pts_state_t;

endpackage

// [rtl/pts_delay_timer.sv]
// microsecond delay timer for command-to-action waits
module pts_delay_timer #(
	parameter int CYC_PER_US = pts_pkg::CYC_PER_US
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic abort,
	input wire logic [pts_pkg::DELAY_US_W-1:0] load_us,
	output logic done
);

	localparam logic [pts_pkg::PRESCALE_W-1:0] PRE_LAST =
		pts_pkg::PRESCALE_W'(CYC_PER_US - 1);

	logic busy;
	logic [pts_pkg::DELAY_US_W-1:0] us_left;
	logic [pts_pkg::PRESCALE_W-1:0] prescale;

	wire us_tick = busy && (prescale == PRE_LAST);
	wire expire = busy && (us_left == '0);

	// =====================================================================
	// countdown
	always_ff @(posedge clk) begin
		if (rst || abort) begin
			busy <= 1'b0;
			us_left <= '0;
			prescale <= '0;
		end else if (start) begin
			busy <= 1'b1;
			us_left <= load_us;
			prescale <= '0;
		end else if (expire) begin
			busy <= 1'b0;
		end else if (us_tick) begin
			prescale <= '0;
			us_left <= us_left - 1'b1;
		end else if (busy) begin
			prescale <= prescale + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || abort) begin
			done <= 1'b0;
		end else begin
			done <= expire && !start;
		end
	end

endmodule

// [rtl/pts_config_bank.sv]
// packet options, command delay and sync word register bank with command timing
module pts_config_bank #(
	parameter int CYC_PER_US = pts_pkg::CYC_PER_US
) (
	input wire logic clk,
	input wire logic rst,
	// register port
	input pts_pkg::pts_reg_req_t reg_req,
	output logic [7:0] reg_rd_data,
	// surrounding configuration
	input wire logic delay_disable,
	input wire logic proprietary_mode,
	input wire logic [4:0] sync_len,
	// commands and frame events
	input wire logic receive_command,
	input wire logic transmit_command,
	input pts_pkg::pts_frame_evt_t frame_evt,
	// control outputs
	output logic extension_enable,
	output logic synth_skip,
	output logic synth_calibrate,
	output pts_pkg::pts_fcs_ctl_t fcs_ctl,
	output logic frame_search_start,
	output logic quality_window_start,
	output logic sync_search_start,
	output logic transmit_enter,
	output logic delay_pending,
	output logic packet_received,
	output logic frame_check_error,
	output logic [pts_pkg::SYNC_W-1:0] sync_word,
	output logic [pts_pkg::SYNC_W-1:0] sync_mask,
	output logic sync_detect_enable
);

	// =====================================================================
	// helpers
	function automatic logic [pts_pkg::DELAY_US_W-1:0] total_delay_us(
		input logic [7:0] base,
		input logic [7:0] ext
	);
		logic [pts_pkg::DELAY_US_W-1:0] scaled;
		scaled = pts_pkg::DELAY_US_W'(ext) * pts_pkg::DELAY_US_W'(pts_pkg::EXT_STEP_US);
		total_delay_us = pts_pkg::DELAY_US_W'(base) + scaled;
	endfunction

	function automatic logic [pts_pkg::SYNC_W-1:0] len_to_mask(input logic [4:0] len);
		logic [4:0] clamped;
		clamped = (len > pts_pkg::SYNC_LEN_MAX) ? pts_pkg::SYNC_LEN_MAX : len;
		len_to_mask = pts_pkg::SYNC_W'((25'h1 << clamped) - 25'h1);
	endfunction

	// =====================================================================
	// register storage
	logic [7:0] packet_options;
	logic [7:0] receive_command_delay;
	logic [7:0] transmit_command_delay;
	logic [7:0] command_delay_extension;
	logic [7:0] sync_pattern_low;
	logic [7:0] sync_pattern_mid;
	logic [7:0] sync_pattern_high;

	wire hit_options = reg_req.addr == pts_pkg::ADDR_PACKET_OPTIONS;
	wire hit_rx_delay = reg_req.addr == pts_pkg::ADDR_RX_CMD_DELAY;
	wire hit_tx_delay = reg_req.addr == pts_pkg::ADDR_TX_CMD_DELAY;
	wire hit_ext = reg_req.addr == pts_pkg::ADDR_CMD_DELAY_EXT;
	wire hit_sync_low = reg_req.addr == pts_pkg::ADDR_SYNC_LOW;
	wire hit_sync_mid = reg_req.addr == pts_pkg::ADDR_SYNC_MID;
	wire hit_sync_high = reg_req.addr == pts_pkg::ADDR_SYNC_HIGH;

	wire wr_options = reg_req.wr && hit_options;
	wire wr_rx_delay = reg_req.wr && hit_rx_delay;
	wire wr_tx_delay = reg_req.wr && hit_tx_delay;
	wire wr_ext = reg_req.wr && hit_ext;
	wire wr_sync_low = reg_req.wr && hit_sync_low;
	wire wr_sync_mid = reg_req.wr && hit_sync_mid;
	wire wr_sync_high = reg_req.wr && hit_sync_high;

	always_ff @(posedge clk) begin
		if (rst) begin
			packet_options <= pts_pkg::RST_PACKET_OPTIONS;
			receive_command_delay <= pts_pkg::RST_RX_CMD_DELAY;
			transmit_command_delay <= pts_pkg::RST_TX_CMD_DELAY;
			command_delay_extension <= pts_pkg::RST_CMD_DELAY_EXT;
		end else begin
			if (wr_options) begin
				packet_options <= reg_req.data;
			end
			if (wr_rx_delay) begin
				receive_command_delay <= reg_req.data;
			end
			if (wr_tx_delay) begin
				transmit_command_delay <= reg_req.data;
			end
			if (wr_ext) begin
				command_delay_extension <= reg_req.data;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sync_pattern_low <= pts_pkg::RST_SYNC_LOW;
			sync_pattern_mid <= pts_pkg::RST_SYNC_MID;
			sync_pattern_high <= pts_pkg::RST_SYNC_HIGH;
		end else begin
			if (wr_sync_low) begin
				sync_pattern_low <= reg_req.data;
			end
			if (wr_sync_mid) begin
				sync_pattern_mid <= reg_req.data;
			end
			if (wr_sync_high) begin
				sync_pattern_high <= reg_req.data;
			end
		end
	end

	// =====================================================================
	// read path
	logic [7:0] read_mux;

	always_comb begin
		if (hit_options) begin
			read_mux = packet_options;
		end else if (hit_rx_delay) begin
			read_mux = receive_command_delay;
		end else if (hit_tx_delay) begin
			read_mux = transmit_command_delay;
		end else if (hit_ext) begin
			read_mux = command_delay_extension;
		end else if (hit_sync_low) begin
			read_mux = sync_pattern_low;
		end else if (hit_sync_mid) begin
			read_mux = sync_pattern_mid;
		end else if (hit_sync_high) begin
			read_mux = sync_pattern_high;
		end else begin
			read_mux = pts_pkg::READ_UNMAPPED;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rd_data <= pts_pkg::READ_UNMAPPED;
		end else if (reg_req.rd) begin
			reg_rd_data <= read_mux;
		end
	end

	// =====================================================================
	// option decode
	wire opt_extension = packet_options[pts_pkg::BIT_EXTENSION_EN];
	wire opt_synth_skip = packet_options[pts_pkg::BIT_SYNTH_SKIP];
	wire opt_fcs_off = packet_options[pts_pkg::BIT_FCS_OFF];

	pts_pkg::pts_fcs_ctl_t next_fcs_ctl;

	assign next_fcs_ctl.rx_check = !opt_fcs_off;
	assign next_fcs_ctl.rx_overwrite_quality = !opt_fcs_off && !proprietary_mode;
	assign next_fcs_ctl.tx_append = !opt_fcs_off;
	assign next_fcs_ctl.tx_from_buffer = opt_fcs_off;

	always_ff @(posedge clk) begin
		if (rst) begin
			extension_enable <= 1'b0;
			synth_skip <= 1'b0;
			fcs_ctl <= '0;
		end else begin
			extension_enable <= opt_extension;
			synth_skip <= opt_synth_skip;
			fcs_ctl <= next_fcs_ctl;
		end
	end

	// =====================================================================
	// command sequencing
	pts_pkg::pts_state_t state;
	pts_pkg::pts_state_t next_state;

	logic latched_proprietary;
	logic [pts_pkg::SYNC_W-1:0] next_sync_word;
	logic [pts_pkg::DELAY_US_W-1:0] cmd_delay_us;
	logic timer_done;

	wire cmd_tx = transmit_command;
	wire cmd_rx = receive_command && !transmit_command;
	wire cmd_any = cmd_tx || cmd_rx;
	wire immediate = cmd_any && delay_disable;
	wire timed_start = cmd_any && !delay_disable;

	assign next_sync_word = {sync_pattern_high, sync_pattern_mid, sync_pattern_low};

	// latched at command, so later writes leave a running delay alone
	assign cmd_delay_us = cmd_tx ?
		total_delay_us(transmit_command_delay, command_delay_extension) :
		total_delay_us(receive_command_delay, command_delay_extension);

	always_comb begin
		next_state = state;
		if (timed_start) begin
			next_state = cmd_tx ? pts_pkg::PTS_TX_WAIT : pts_pkg::PTS_RX_WAIT;
		end else if (immediate) begin
			next_state = pts_pkg::PTS_IDLE;
		end else begin
			case (state)
				pts_pkg::PTS_RX_WAIT: begin
					if (timer_done) begin
						next_state = pts_pkg::PTS_IDLE;
					end
				end
				pts_pkg::PTS_TX_WAIT: begin
					if (timer_done) begin
						next_state = pts_pkg::PTS_IDLE;
					end
				end
				default: begin
					next_state = pts_pkg::PTS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= pts_pkg::PTS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	pts_delay_timer #(
		.CYC_PER_US(CYC_PER_US)
	) u_timer (
		.clk(clk),
		.rst(rst),
		.start(timed_start),
		.abort(immediate),
		.load_us(cmd_delay_us),
		.done(timer_done)
	);

	// =====================================================================
	// command-time latches
	always_ff @(posedge clk) begin
		if (rst) begin
			latched_proprietary <= 1'b0;
		end else if (cmd_any) begin
			latched_proprietary <= proprietary_mode;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sync_word <= {pts_pkg::RST_SYNC_HIGH, pts_pkg::RST_SYNC_MID, pts_pkg::RST_SYNC_LOW};
			sync_mask <= len_to_mask(pts_pkg::SYNC_LEN_MAX);
			sync_detect_enable <= 1'b1;
		end else if (cmd_any) begin
			sync_word <= next_sync_word;
			sync_mask <= len_to_mask(sync_len);
			sync_detect_enable <= sync_len != 5'h00;
		end
	end

	// =====================================================================
	// action strobes
	wire rx_fire = (state == pts_pkg::PTS_RX_WAIT && timer_done && !cmd_any) ||
		(immediate && cmd_rx);
	wire tx_fire = (state == pts_pkg::PTS_TX_WAIT && timer_done && !cmd_any) ||
		(immediate && cmd_tx);
	wire rx_prop = immediate ? proprietary_mode : latched_proprietary;

	always_ff @(posedge clk) begin
		if (rst) begin
			frame_search_start <= 1'b0;
			quality_window_start <= 1'b0;
			sync_search_start <= 1'b0;
		end else begin
			frame_search_start <= rx_fire && !rx_prop;
			quality_window_start <= rx_fire && !rx_prop;
			sync_search_start <= rx_fire && rx_prop;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			transmit_enter <= 1'b0;
		end else begin
			transmit_enter <= tx_fire;
		end
	end

	// calibration follows the published skip flag, so both agree at every command
	always_ff @(posedge clk) begin
		if (rst) begin
			synth_calibrate <= 1'b0;
		end else begin
			synth_calibrate <= cmd_any && !synth_skip;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			delay_pending <= 1'b0;
		end else begin
			delay_pending <= next_state != pts_pkg::PTS_IDLE;
		end
	end

	// =====================================================================
	// frame reception events
	always_ff @(posedge clk) begin
		if (rst) begin
			packet_received <= 1'b0;
		end else begin
			packet_received <= frame_evt.received;
		end
	end

	// judged against the published check control, not the raw option bit
	always_ff @(posedge clk) begin
		if (rst) begin
			frame_check_error <= 1'b0;
		end else begin
			frame_check_error <= frame_evt.received && fcs_ctl.rx_check &&
				!frame_evt.check_ok;
		end
	end

endmodule

// [verif/pts_host_model.sv]
// host model driving the register port of the configuration bank
module pts_host_model (
	input wire logic clk,
	input wire logic [7:0] reg_rd_data,
	output pts_pkg::pts_reg_req_t reg_req
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ext_loaded = 1'h0;
	logic cont_tx = 1'h0;
	initial reg_req = '0;
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == pts_pkg::ADDR_PACKET_OPTIONS) begin
			v[7:5] = 3'h0;
			v[2:1] = 2'h2;
			v[4] = d[4] & ext_loaded;
			v[3] = d[3] & cont_tx;
		end
		@(posedge clk);
		reg_req <= '{wr: 1'h1, rd: 1'h0, addr: a, data: v};
		@(posedge clk);
		// released lines show the inverse, not the last value
		reg_req <= '{wr: 1'h0, rd: 1'h0, addr: ~a, data: ~v};
	endtask
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_req <= '{wr: 1'h0, rd: 1'h1, addr: a, data: 8'h00};
		@(posedge clk);
		reg_req <= '{wr: 1'h0, rd: 1'h0, addr: ~a, data: 8'hff};
		@(posedge clk);
		#1 d = reg_rd_data;
	endtask
endmodule

// [verif/pts_config_bank_chk.sv]
// assertion checker for the configuration bank ports
module pts_config_bank_chk #(
	parameter int CYC_PER_US = pts_pkg::CYC_PER_US
) (
	input wire logic clk,
	input wire logic rst,
	input pts_pkg::pts_reg_req_t reg_req,
	input wire logic delay_disable,
	input wire logic receive_command,
	input wire logic transmit_command,
	input pts_pkg::pts_frame_evt_t frame_evt,
	input wire logic extension_enable,
	input wire logic synth_skip,
	input wire logic synth_calibrate,
	input pts_pkg::pts_fcs_ctl_t fcs_ctl,
	input wire logic frame_search_start,
	input wire logic quality_window_start,
	input wire logic sync_search_start,
	input wire logic transmit_enter,
	input wire logic delay_pending,
	input wire logic packet_received,
	input wire logic frame_check_error,
	input wire logic [pts_pkg::SYNC_W-1:0] sync_word,
	input wire logic [pts_pkg::SYNC_W-1:0] sync_mask,
	input wire logic sync_detect_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_cmd;
		receive_command || transmit_command;
	endsequence
	sequence s_action;
		frame_search_start || sync_search_start || transmit_enter;
	endsequence
	property p_ext;
		reg_req.wr && reg_req.addr == pts_pkg::ADDR_PACKET_OPTIONS |->
			##2 extension_enable == $past(reg_req.data[4], 2);
	endproperty
	property p_skip;
		reg_req.wr && reg_req.addr == pts_pkg::ADDR_PACKET_OPTIONS |->
			##2 synth_skip == $past(reg_req.data[3], 2);
	endproperty
	property p_cal;
		s_cmd |=> synth_calibrate == !$past(synth_skip);
	endproperty
	property p_pend;
		s_cmd ##0 !delay_disable |=> delay_pending;
	endproperty
	property p_bypass;
		s_cmd ##0 delay_disable |=> s_action;
	endproperty
	property p_end;
		$fell(delay_pending) |-> s_action;
	endproperty
	property p_pair;
		frame_search_start |-> quality_window_start && !sync_search_start;
	endproperty
	property p_rcv;
		frame_evt.received |=> packet_received;
	endproperty
	property p_err;
		frame_evt.received |=>
			frame_check_error == ($past(fcs_ctl.rx_check) && !$past(frame_evt.check_ok));
	endproperty
	property p_fcs;
		!$past(rst) |-> fcs_ctl.tx_append != fcs_ctl.tx_from_buffer;
	endproperty
	property p_sync;
		sync_detect_enable == (sync_mask != 24'h000000);
	endproperty
	property p_hold;
		!$past(receive_command || transmit_command) |-> $stable(sync_word);
	endproperty
	a_ext: assert property (p_ext) else $error("extension enable mismatch");
	a_skip: assert property (p_skip) else $error("synth skip mismatch");
	a_cal: assert property (p_cal) else $error("calibration pulse wrong");
	a_pend: assert property (p_pend) else $error("delay not pending");
	a_bypass: assert property (p_bypass) else $error("bypass action late");
	a_end: assert property (p_end) else $error("delay ended without action");
	a_pair: assert property (p_pair) else $error("rx strobes disagree");
	a_rcv: assert property (p_rcv) else $error("packet received missing");
	a_err: assert property (p_err) else $error("check error wrong");
	a_fcs: assert property (p_fcs) else $error("append and buffer both");
	a_sync: assert property (p_sync) else $error("sync enable wrong");
	a_hold: assert property (p_hold) else $error("sync word moved");
endmodule

bind pts_config_bank pts_config_bank_chk #(.CYC_PER_US(CYC_PER_US)) u_chk (
	.clk, .rst, .reg_req, .delay_disable, .receive_command, .transmit_command, .frame_evt,
	.extension_enable, .synth_skip, .synth_calibrate, .fcs_ctl, .frame_search_start,
	.quality_window_start, .sync_search_start, .transmit_enter, .delay_pending,
	.packet_received, .frame_check_error, .sync_word, .sync_mask, .sync_detect_enable
);

// [verif/pts_config_bank_test.sv]
// self-checking bench for the configuration bank
module pts_config_bank_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic delay_disable = 1'h0;
	logic proprietary_mode = 1'h0;
	logic [4:0] sync_len = 5'h18;
	logic receive_command = 1'h0;
	logic transmit_command = 1'h0;
	pts_pkg::pts_frame_evt_t frame_evt = '0;
	pts_pkg::pts_reg_req_t reg_req;
	pts_pkg::pts_fcs_ctl_t fcs_ctl;
	logic [7:0] reg_rd_data;
	logic extension_enable, synth_skip, synth_calibrate, frame_search_start;
	logic quality_window_start, sync_search_start, transmit_enter, delay_pending;
	logic packet_received, frame_check_error, sync_detect_enable;
	logic [23:0] sync_word, sync_mask;
	int errors = 0;
	int total_checks = 0;
	logic [7:0] rv [7] = '{8'h04, 8'hc0, 8'hc0, 8'h00, 8'h31, 8'h7a, 8'haa};

	initial forever #50 clk = ~clk;

	pts_host_model host (.clk, .reg_rd_data, .reg_req);
	pts_config_bank #(.CYC_PER_US(1)) dut (
		.clk, .rst, .reg_req, .reg_rd_data, .delay_disable, .proprietary_mode, .sync_len,
		.receive_command, .transmit_command, .frame_evt, .extension_enable, .synth_skip,
		.synth_calibrate, .fcs_ctl, .frame_search_start, .quality_window_start,
		.sync_search_start, .transmit_enter, .delay_pending, .packet_received,
		.frame_check_error, .sync_word, .sync_mask, .sync_detect_enable
	);

	// =====================================================================
	// helpers
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(a, d);
		check({16'h0, d}, {16'h0, exp});
	endtask
	task automatic run_cmd(input logic tx, input int exp_n, input logic [2:0] exp_s);
		int n;
		@(posedge clk);
		if (tx) transmit_command <= 1'h1;
		else receive_command <= 1'h1;
		@(posedge clk);
		transmit_command <= 1'h0;
		receive_command <= 1'h0;
		n = 0;
		#1;
		while (!(frame_search_start | sync_search_start | transmit_enter) && n < 3000) begin
			@(posedge clk);
			#1 n++;
		end
		check(24'(n), 24'(exp_n));
		check({21'h0, frame_search_start, sync_search_start, transmit_enter}, {21'h0, exp_s});
	endtask
	task automatic frame(input logic ok, input logic exp_err);
		@(posedge clk);
		frame_evt <= '{received: 1'h1, check_ok: ok};
		@(posedge clk);
		frame_evt <= '0;
		#1;
		check({22'h0, packet_received, frame_check_error}, {22'h0, 1'h1, exp_err});
	endtask
	task automatic finish_test;
		if (errors == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// =====================================================================
	// tests
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 7; i++) rd_chk(10'h108 + 10'(i), rv[i]);
		host.wr(10'h10f, 8'h55);
		rd_chk(10'h10f, 8'h00);
		for (int i = 1; i < 7; i++) begin
			host.wr(10'h108 + 10'(i), 8'ha5 ^ 8'(i));
			rd_chk(10'h108 + 10'(i), 8'ha5 ^ 8'(i));
		end
		host.ext_loaded = 1'h1;
		host.cont_tx = 1'h1;
		host.wr(10'h108, 8'h18);
		rd_chk(10'h108, 8'h1c);
		check({22'h0, extension_enable, synth_skip}, 24'h3);
		host.wr(10'h108, 8'h00);
		host.wr(10'h109, 8'h05);
		host.wr(10'h10a, 8'h03);
		host.wr(10'h10b, 8'h01);
		host.wr(10'h10c, 8'h11);
		host.wr(10'h10d, 8'h22);
		host.wr(10'h10e, 8'h33);
		@(posedge clk);
		sync_len <= 5'h0c;
		run_cmd(1'h0, 11, 3'h4);
		check(sync_word, 24'h332211);
		check(sync_mask, 24'h000fff);
		check({20'h0, fcs_ctl}, 24'he);
		frame(1'h0, 1'h1);
		frame(1'h1, 1'h0);
		host.wr(10'h108, 8'h01);
		sync_len <= 5'h00;
		run_cmd(1'h0, 11, 3'h4);
		check({20'h0, fcs_ctl}, 24'h1);
		check({23'h0, sync_detect_enable}, 24'h0);
		frame(1'h0, 1'h0);
		proprietary_mode <= 1'h1;
		run_cmd(1'h0, 11, 3'h2);
		check({20'h0, fcs_ctl}, 24'h1);
		host.wr(10'h108, 8'h00);
		run_cmd(1'h0, 11, 3'h2);
		check({20'h0, fcs_ctl}, 24'ha);
		fork
			run_cmd(1'h1, 9, 3'h1);
			begin
				repeat (4) @(posedge clk);
				host.wr(10'h10a, 8'h40);
			end
		join
		delay_disable <= 1'h1;
		run_cmd(1'h1, 0, 3'h1);
		delay_disable <= 1'h0;
		host.wr(10'h10a, 8'h00);
		host.wr(10'h10b, 8'h00);
		run_cmd(1'h1, 2, 3'h1);
		finish_test;
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		finish_test;
	end
endmodule
